// >>> hdl/flash_prot_pkg.sv
// Purpose: Shared constants and types for the Flash sector protection block.
// Assumes: 32-bit AXI4-Lite register access, 16-bit Flash address space.
// Notes: Printed register offsets are indexes; the byte address is four times the index.
package flash_prot_pkg;

   localparam logic [7:0] CFG_INDEX = 8'h04;
   localparam logic [7:0] STATUS_INDEX = 8'h05;
   localparam logic [7:0] CMD_INDEX = 8'h06;
   localparam logic [9:0] CFG_ADDR = {CFG_INDEX, 2'b00};
   localparam logic [9:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
   localparam logic [9:0] CMD_ADDR = {CMD_INDEX, 2'b00};

   localparam int POLARITY_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int HIGH_DIS_BIT = 5;
   localparam int HIGH_SIZE_LSB = 3;
   localparam int LOW_DIS_BIT = 2;
   localparam int LOW_SIZE_LSB = 0;

   localparam int STATUS_VIOL_BIT = 5;
   localparam int STATUS_LOADED_BIT = 7;

   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_CODE_LSB = 16;

   localparam logic [7:0] CFG_RESET = 8'hFF;
   localparam logic [15:0] NV_PROT_ADDR = 16'hFF0D;

   localparam logic [15:0] LOW_BASE = 16'h4000;
   localparam logic [15:0] LOW_END_0 = 16'h43FF;
   localparam logic [15:0] LOW_END_1 = 16'h47FF;
   localparam logic [15:0] LOW_END_2 = 16'h4FFF;
   localparam logic [15:0] LOW_END_3 = 16'h5FFF;
   localparam logic [15:0] HIGH_BASE_0 = 16'hF800;
   localparam logic [15:0] HIGH_BASE_1 = 16'hF000;
   localparam logic [15:0] HIGH_BASE_2 = 16'hE000;
   localparam logic [15:0] HIGH_BASE_3 = 16'hC000;

   // Row = present scenario {polarity, high disable, low disable}, bit = allowed target.
   localparam logic [63:0] SCENARIO_ALLOWED = {
      8'b1111_1111, 8'b0101_1010, 8'b0011_1100, 8'b0001_1000,
      8'b0000_1000, 8'b0000_1100, 8'b0000_1010, 8'b0000_1111};

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_PROGRAM = 2'b01,
      CMD_SECTOR_ERASE = 2'b10,
      CMD_MASS_ERASE = 2'b11
   } cmd_code_t;

   typedef enum logic [1:0] {
      PH_LOAD_REQ = 2'b00,
      PH_LOAD_WAIT = 2'b01,
      PH_RUN = 2'b10
   } phase_t;

endpackage

// >>> hdl/flash_sector_protection.sv
// Purpose: Flash sector protection register, write restrictions and command protection check.
// Assumes: Nonvolatile byte read port and Flash command port run on sys_clk.
// Notes: Bus readys stay low until the reset-time configuration load has finished.
`timescale 1ns/100ps
module flash_sector_protection (
   input wire logic sys_clk, // System clock, 40 MHz.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic clk_en, // Clock enable; while low, all state holds unless sys_rst is high.
   input wire logic [31:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [31:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   output logic nv_read_req, // Request for the nonvolatile protection byte.
   output logic [15:0] nv_read_addr, // Address of the nonvolatile protection byte.
   input wire logic [7:0] nv_read_data, // Nonvolatile byte returned.
   input wire logic nv_read_valid, // Nonvolatile byte valid strobe.
   output logic cmd_launch, // One-cycle launch of an allowed command.
   output logic [1:0] cmd_code, // Code of the launched command.
   output logic [15:0] cmd_addr, // Flash address of the launched command.
   output logic [7:0] prot_cfg, // Active protection configuration.
   output logic protection_violation_flag // Sticky protection violation.
);

   typedef struct packed {
      flash_prot_pkg::phase_t phase;
      logic [7:0] cfg;
      logic viol;
      logic nv_req;
      logic [15:0] nv_addr;
      logic aw_held;
      logic w_held;
      logic [9:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic launch;
      logic [1:0] code;
      logic [15:0] caddr;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Whether an address falls in a protected area under a configuration.
   function automatic logic is_protected(input logic [7:0] cfg, input logic [15:0] addr);
      logic [15:0] high_base;
      logic [15:0] low_end;
      logic in_high;
      logic in_low;
      logic selected;
      high_base = flash_prot_pkg::HIGH_BASE_0;
      low_end = flash_prot_pkg::LOW_END_0;
      unique case (cfg[flash_prot_pkg::HIGH_SIZE_LSB +: 2])
         2'b00: high_base = flash_prot_pkg::HIGH_BASE_0;
         2'b01: high_base = flash_prot_pkg::HIGH_BASE_1;
         2'b10: high_base = flash_prot_pkg::HIGH_BASE_2;
         2'b11: high_base = flash_prot_pkg::HIGH_BASE_3;
      endcase
      unique case (cfg[flash_prot_pkg::LOW_SIZE_LSB +: 2])
         2'b00: low_end = flash_prot_pkg::LOW_END_0;
         2'b01: low_end = flash_prot_pkg::LOW_END_1;
         2'b10: low_end = flash_prot_pkg::LOW_END_2;
         2'b11: low_end = flash_prot_pkg::LOW_END_3;
      endcase
      in_high = (addr >= high_base);
      in_low = (addr >= flash_prot_pkg::LOW_BASE) && (addr <= low_end);
      selected = (!cfg[flash_prot_pkg::HIGH_DIS_BIT] && in_high) ||
                 (!cfg[flash_prot_pkg::LOW_DIS_BIT] && in_low);
      if (cfg[flash_prot_pkg::POLARITY_BIT]) begin
         is_protected = selected;
      end else begin
         is_protected = !selected;
      end
   endfunction

   // Applies the field restrictions to a software write of the configuration.
   function automatic logic [7:0] cfg_merge(input logic [7:0] cur, input logic [7:0] wr);
      logic [7:0] res;
      res = cur;
      res[flash_prot_pkg::POLARITY_BIT] = cur[flash_prot_pkg::POLARITY_BIT] &
                                          wr[flash_prot_pkg::POLARITY_BIT];
      res[flash_prot_pkg::HIGH_DIS_BIT] = wr[flash_prot_pkg::HIGH_DIS_BIT];
      res[flash_prot_pkg::LOW_DIS_BIT] = wr[flash_prot_pkg::LOW_DIS_BIT];
      if (cur[flash_prot_pkg::HIGH_DIS_BIT]) begin
         res[flash_prot_pkg::HIGH_SIZE_LSB +: 2] = wr[flash_prot_pkg::HIGH_SIZE_LSB +: 2];
      end
      if (cur[flash_prot_pkg::LOW_DIS_BIT]) begin
         res[flash_prot_pkg::LOW_SIZE_LSB +: 2] = wr[flash_prot_pkg::LOW_SIZE_LSB +: 2];
      end
      cfg_merge = res;
   endfunction

   // Scenario number is {polarity, high disable, low disable}.
   function automatic logic [2:0] scenario(input logic [7:0] cfg);
      scenario = {cfg[flash_prot_pkg::POLARITY_BIT], cfg[flash_prot_pkg::HIGH_DIS_BIT],
                  cfg[flash_prot_pkg::LOW_DIS_BIT]};
   endfunction

   always_comb begin
      logic [7:0] merged;
      logic [2:0] from_sc;
      logic [2:0] to_sc;
      logic viol_set;
      logic viol_clr;
      logic [15:0] req_addr;
      logic [1:0] req_code;
      merged = 8'h00;
      from_sc = 3'b000;
      to_sc = 3'b000;
      viol_set = 1'b0;
      viol_clr = 1'b0;
      req_addr = 16'h0000;
      req_code = 2'b00;
      state_next = state_reg;
      state_next.launch = 1'b0;

      unique case (state_reg.phase)
         flash_prot_pkg::PH_LOAD_REQ: begin
            state_next.nv_req = 1'b1;
            state_next.phase = flash_prot_pkg::PH_LOAD_WAIT;
         end
         flash_prot_pkg::PH_LOAD_WAIT: begin
            if (nv_read_valid) begin
               state_next.cfg = nv_read_data;
               state_next.nv_req = 1'b0;
               state_next.phase = flash_prot_pkg::PH_RUN;
               state_next.awready = 1'b1;
               state_next.wready = 1'b1;
               state_next.arready = 1'b1;
            end
         end
         flash_prot_pkg::PH_RUN: begin
            if (s_axi_awvalid && state_reg.awready) begin
               state_next.aw_held = 1'b1;
               state_next.awready = 1'b0;
               state_next.waddr = s_axi_awaddr[9:0];
            end
            if (s_axi_wvalid && state_reg.wready) begin
               state_next.w_held = 1'b1;
               state_next.wready = 1'b0;
               state_next.wdata = s_axi_wdata;
               state_next.wstrb = s_axi_wstrb;
            end
            if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
               state_next.aw_held = 1'b0;
               state_next.w_held = 1'b0;
               state_next.bvalid = 1'b1;
               state_next.bresp = flash_prot_pkg::RESP_OKAY;
               unique case (state_reg.waddr)
                  flash_prot_pkg::CFG_ADDR: begin
                     if (state_reg.wstrb[0]) begin
                        merged = cfg_merge(state_reg.cfg, state_reg.wdata[7:0]);
                        from_sc = scenario(state_reg.cfg);
                        to_sc = scenario(merged);
                        if (flash_prot_pkg::SCENARIO_ALLOWED[{from_sc, to_sc}]) begin
                           state_next.cfg = merged;
                        end
                     end
                  end
                  flash_prot_pkg::STATUS_ADDR: begin
                     viol_clr = state_reg.wstrb[0] &&
                                state_reg.wdata[flash_prot_pkg::STATUS_VIOL_BIT];
                  end
                  flash_prot_pkg::CMD_ADDR: begin
                     req_addr = state_reg.wdata[flash_prot_pkg::CMD_ADDR_LSB +: 16];
                     req_code = state_reg.wdata[flash_prot_pkg::CMD_CODE_LSB +: 2];
                     if (!state_reg.viol && (&state_reg.wstrb[2:0]) &&
                         req_code != flash_prot_pkg::CMD_NONE) begin
                        if (req_code == flash_prot_pkg::CMD_MASS_ERASE) begin
                           viol_set = !(state_reg.cfg[flash_prot_pkg::POLARITY_BIT] &&
                                        state_reg.cfg[flash_prot_pkg::HIGH_DIS_BIT] &&
                                        state_reg.cfg[flash_prot_pkg::LOW_DIS_BIT]);
                        end else begin
                           viol_set = is_protected(state_reg.cfg, req_addr);
                        end
                        state_next.launch = !viol_set;
                        state_next.code = req_code;
                        state_next.caddr = req_addr;
                     end
                  end
                  default: begin
                     state_next.bresp = flash_prot_pkg::RESP_SLVERR;
                  end
               endcase
            end
            if (state_reg.bvalid && s_axi_bready) begin
               state_next.bvalid = 1'b0;
               state_next.awready = 1'b1;
               state_next.wready = 1'b1;
            end
            // Set wins over a clear that arrives in the same cycle.
            if (viol_set) begin
               state_next.viol = 1'b1;
            end else if (viol_clr) begin
               state_next.viol = 1'b0;
            end
            if (s_axi_arvalid && state_reg.arready) begin
               state_next.arready = 1'b0;
               state_next.rvalid = 1'b1;
               state_next.rresp = flash_prot_pkg::RESP_OKAY;
               state_next.rdata = 32'h0000_0000;
               unique case (s_axi_araddr[9:0])
                  flash_prot_pkg::CFG_ADDR: begin
                     state_next.rdata[7:0] = state_reg.cfg;
                  end
                  flash_prot_pkg::STATUS_ADDR: begin
                     state_next.rdata[flash_prot_pkg::STATUS_VIOL_BIT] = state_reg.viol;
                     state_next.rdata[flash_prot_pkg::STATUS_LOADED_BIT] = 1'b1;
                  end
                  flash_prot_pkg::CMD_ADDR: begin
                     state_next.rdata[flash_prot_pkg::CMD_ADDR_LSB +: 16] = state_reg.caddr;
                     state_next.rdata[flash_prot_pkg::CMD_CODE_LSB +: 2] = state_reg.code;
                  end
                  default: begin
                     state_next.rresp = flash_prot_pkg::RESP_SLVERR;
                  end
               endcase
            end
            if (state_reg.rvalid && s_axi_rready) begin
               state_next.rvalid = 1'b0;
               state_next.arready = 1'b1;
            end
         end
         default: begin
            state_next.phase = flash_prot_pkg::PH_LOAD_REQ;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '{phase: flash_prot_pkg::PH_LOAD_REQ,
                        cfg: flash_prot_pkg::CFG_RESET,
                        nv_addr: flash_prot_pkg::NV_PROT_ADDR,
                        bresp: flash_prot_pkg::RESP_OKAY,
                        rresp: flash_prot_pkg::RESP_OKAY,
                        default: '0};
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign s_axi_awready = state_reg.awready;
   assign s_axi_wready = state_reg.wready;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_arready = state_reg.arready;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign s_axi_rvalid = state_reg.rvalid;
   assign nv_read_req = state_reg.nv_req;
   assign nv_read_addr = state_reg.nv_addr;
   assign cmd_launch = state_reg.launch;
   assign cmd_code = state_reg.code;
   assign cmd_addr = state_reg.caddr;
   assign prot_cfg = state_reg.cfg;
   assign protection_violation_flag = state_reg.viol;

endmodule // flash_sector_protection

// >>> tb/flash_sector_protection_asserts.sv
// Purpose: Port-level checker for the Flash sector protection block.
// Assumes: Bound to flash_sector_protection; one clock domain.
// Notes: Config changes and flag clears outside the load must come with a write response.
`timescale 1ns/100ps
module flash_sector_protection_asserts (
   input wire logic sys_clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic nv_read_req, // Load request.
   input wire logic nv_read_valid, // Load strobe.
   input wire logic cmd_launch, // Launch pulse.
   input wire logic [7:0] prot_cfg, // Active config.
   input wire logic protection_violation_flag // Violation flag.
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   property p_load;
      $fell(nv_read_req) |-> $past(nv_read_valid);
   endproperty
   a_load: assert property (p_load) else $error("load ended without a strobe");
   property p_pol;
      (!prot_cfg[7] && !nv_read_req) |=> !prot_cfg[7];
   endproperty
   a_pol: assert property (p_pol) else $error("polarity rose");
   property p_low;
      (!prot_cfg[2] && !nv_read_req) |=> $stable(prot_cfg[1:0]);
   endproperty
   a_low: assert property (p_low) else $error("low size moved while frozen");
   property p_high;
      (!prot_cfg[5] && !nv_read_req) |=> $stable(prot_cfg[4:3]);
   endproperty
   a_high: assert property (p_high) else $error("high size moved while frozen");
   property p_cfg;
      ($changed(prot_cfg) && !$past(nv_read_req)) |-> $rose(s_axi_bvalid);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config changed without a write");
   property p_launch;
      cmd_launch |-> $rose(s_axi_bvalid) ##1 !cmd_launch;
   endproperty
   a_launch: assert property (p_launch) else $error("launch not a write pulse");
   property p_launch_flag;
      cmd_launch |-> !$past(protection_violation_flag) && !protection_violation_flag;
   endproperty
   a_launch_flag: assert property (p_launch_flag) else $error("launch beside a violation");
   property p_flag_fall;
      $fell(protection_violation_flag) |-> $rose(s_axi_bvalid);
   endproperty
   a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without a write");
   property p_read;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read: assert property (p_read) else $error("read not answered");
   c_launch: cover property (cmd_launch);
   c_viol: cover property ($rose(protection_violation_flag));
   c_cfg: cover property ($changed(prot_cfg) && !nv_read_req);
endmodule // flash_sector_protection_asserts

bind flash_sector_protection flash_sector_protection_asserts u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .nv_read_req(nv_read_req), .nv_read_valid(nv_read_valid), .cmd_launch(cmd_launch),
   .prot_cfg(prot_cfg), .protection_violation_flag(protection_violation_flag)
);

// >>> tb/tb_flash_sector_protection.sv
// Purpose: Self-checking bench for the Flash sector protection block.
// Assumes: 40 MHz clock; the bench acts as bus master and nonvolatile store.
// Notes: A row with a nonzero load byte resets and reloads the block first.
`timescale 1ns/100ps
module tb_flash_sector_protection;
   typedef struct packed {
      logic [7:0] nv;
      logic [7:0] w;
      logic [7:0] e;
      logic [1:0] c;
      logic [15:0] a;
      logic l;
   } row_t;
   logic sys_clk, sys_rst, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, nv_read_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, nv_read_req, cmd_launch, protection_violation_flag, launch, flag;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, cmd_code, resp;
   logic [15:0] nv_read_addr, cmd_addr;
   logic [7:0] nv_read_data, prot_cfg;
   int err_count = 0;
   int cmp_count = 0;
   row_t rows [18] = '{
      '{8'hF7, 8'hF7, 8'hF7, 2'h1, 16'hFF0D, 1'b1}, '{8'h00, 8'hF7, 8'hF7, 2'h3, 16'h0000, 1'b1},
      '{8'h00, 8'hF8, 8'hF8, 2'h1, 16'h43FF, 1'b0}, '{8'h00, 8'hFB, 8'hF8, 2'h2, 16'h4400, 1'b1},
      '{8'h00, 8'hF8, 8'hF8, 2'h3, 16'h0000, 1'b0}, '{8'h00, 8'hC8, 8'hC8, 2'h2, 16'hF000, 1'b0},
      '{8'h00, 8'h48, 8'hC8, 2'h1, 16'hEFFF, 1'b1}, '{8'h00, 8'hD0, 8'hC8, 2'h1, 16'hEFFF, 1'b1},
      '{8'h5B, 8'h5B, 8'h5B, 2'h1, 16'hC000, 1'b1}, '{8'h00, 8'hDB, 8'h5B, 2'h1, 16'hBFFF, 1'b0},
      '{8'h00, 8'h5F, 8'h5F, 2'h1, 16'h5FFF, 1'b0}, '{8'h52, 8'h52, 8'h52, 2'h2, 16'hE000, 1'b1},
      '{8'h00, 8'h52, 8'h52, 2'h1, 16'h4FFF, 1'b1}, '{8'h00, 8'h52, 8'h52, 2'h1, 16'h5000, 1'b0},
      '{8'hC1, 8'hC1, 8'hC1, 2'h1, 16'hF7FF, 1'b1}, '{8'h00, 8'hC1, 8'hC1, 2'h1, 16'hF800, 1'b0},
      '{8'h00, 8'hC1, 8'hC1, 2'h2, 16'h47FF, 1'b0}, '{8'h00, 8'hC1, 8'hC1, 2'h1, 16'h4800, 1'b1}};

   flash_sector_protection DUT (
      .sys_clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .nv_read_req, .nv_read_addr, .nv_read_data, .nv_read_valid,
      .cmd_launch, .cmd_code, .cmd_addr, .prot_cfg, .protection_violation_flag
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Responses are taken at the first edge that sees valid, as ready is held high.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      launch = cmd_launch;
      flag = protection_violation_flag;
   endtask

   task automatic axi_read(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask

   task automatic reset_load(input logic [7:0] nv);
      sys_rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk(prot_cfg, 32'h0000_00FF);
      chk(nv_read_req, 32'h0000_0000);
      sys_rst <= 1'b0;
      do @(posedge sys_clk); while (!nv_read_req);
      chk(nv_read_addr, 32'h0000_FF0D);
      nv_read_data <= nv;
      nv_read_valid <= 1'b1;
      @(posedge sys_clk);
      nv_read_valid <= 1'b0;
      nv_read_data <= ~nv;
      @(posedge sys_clk);
      chk(prot_cfg, nv);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      results();
   end

   initial begin
      sys_rst <= 1'b1;
      clk_en <= 1'b1;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      s_axi_rready <= 1'b1;
      s_axi_wstrb <= 4'hF;
      s_axi_awaddr <= 32'h0000_0000;
      s_axi_wdata <= 32'h0000_0000;
      s_axi_araddr <= 32'h0000_0000;
      nv_read_valid <= 1'b0;
      nv_read_data <= 8'h00;
      foreach (rows[i]) begin
         if (rows[i].nv !== 8'h00) reset_load(rows[i].nv);
         axi_write(32'h0000_0010, {24'h00_0000, rows[i].w});
         chk(resp, 32'h0000_0000);
         axi_read(32'h0000_0010);
         chk(rd, {24'h00_0000, rows[i].e});
         axi_write(32'h0000_0018, {14'h0000, rows[i].c, rows[i].a});
         chk(launch, rows[i].l);
         chk(flag, !rows[i].l);
         if (launch) chk({cmd_code, cmd_addr}, {rows[i].c, rows[i].a});
         if (flag) begin
            axi_write(32'h0000_0014, 32'h0000_0020);
            chk(flag, 32'h0000_0000);
         end
      end
      axi_write(32'h0000_0018, 32'h0003_0000);
      chk(flag, 32'h0000_0001);
      axi_write(32'h0000_0018, 32'h0001_4800);
      chk(launch, 32'h0000_0000);
      chk(flag, 32'h0000_0001);
      axi_write(32'h0000_0014, 32'h0000_0000);
      chk(flag, 32'h0000_0001);
      axi_write(32'h0000_0014, 32'h0000_0020);
      axi_read(32'h0000_0014);
      chk(rd, 32'h0000_0080);
      axi_write(32'h0000_0018, 32'h0001_4800);
      chk(launch, 32'h0000_0001);
      axi_read(32'h0000_03FC);
      chk(resp, 32'h0000_0002);
      chk(rd, 32'h0000_0000);
      axi_write(32'h0000_0020, 32'h0000_00FF);
      chk(resp, 32'h0000_0002);
      // With the clock enable low the reset-time load must not start.
      sys_rst <= 1'b1;
      clk_en <= 1'b0;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(nv_read_req, 32'h0000_0000);
      chk(prot_cfg, 32'h0000_00FF);
      clk_en <= 1'b1;
      reset_load(8'hF7);
      results();
   end
endmodule // tb_flash_sector_protection
